// [core/adcsr_pkg.sv]
/*
  Constants, timing figures and state type shared by the serial readout
  block of the 18-bit converter.
  Assumes a 20 MHz system clock; all cycle counts derive from that rate.
*/
package adcsr_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int ADCSR_DATA_W = 18;
  localparam int ADCSR_CNT_W = 8;
  localparam int ADCSR_EDGE_W = 5;

  // ********************************************************************
  // Values after reset
  // ********************************************************************
  localparam logic [ADCSR_DATA_W-1:0] ADCSR_WORD_RST = 18'h0_0000;
  localparam logic [ADCSR_CNT_W-1:0] ADCSR_CNT_RST = 8'h00;
  localparam logic [ADCSR_EDGE_W-1:0] ADCSR_EDGE_RST = 5'h00;

  // ********************************************************************
  // Readout edge counts and MSB bit position
  // ********************************************************************
  localparam logic [ADCSR_EDGE_W-1:0] ADCSR_EDGES_PLAIN = 5'h12;
  localparam logic [ADCSR_EDGE_W-1:0] ADCSR_EDGES_BUSY = 5'h13;
  localparam logic [ADCSR_EDGE_W-1:0] ADCSR_MSB_POS = 5'h11;

  // ********************************************************************
  // Conversion timing
  // ********************************************************************
  localparam int ADCSR_CLK_PERIOD_NS = 50;
  localparam int ADCSR_T_CONV_MIN_NS = 500;
  localparam int ADCSR_T_CONV_MAX_NS = 2500;
  localparam int ADCSR_CONV_MIN_CYC =
    (ADCSR_T_CONV_MIN_NS + ADCSR_CLK_PERIOD_NS - 1) / ADCSR_CLK_PERIOD_NS;
  localparam int ADCSR_CONV_MAX_CYC =
    ADCSR_T_CONV_MAX_NS / ADCSR_CLK_PERIOD_NS;
  localparam int ADCSR_CONV_CYC =
    (ADCSR_CONV_MIN_CYC + ADCSR_CONV_MAX_CYC) / 2;
  localparam logic [ADCSR_CNT_W-1:0] ADCSR_CONV_LOAD =
    ADCSR_CNT_W'(ADCSR_CONV_CYC - 1);

  // ********************************************************************
  // States
  // ********************************************************************
  typedef enum logic {
    st_acquire,
    st_convert
  } adcsr_state_e;

endpackage

// [core/adcsr_readout.sv]
/*
  Conversion start and serial readout logic of an 18-bit converter:
  4-wire chip-select and daisy-chain modes, each with or without busy bit.
  Assumes the host drives the start pin, serial data in and serial clock,
  and resolves the serial output wire from sdo_out and sdo_oe_out.
*/
// Overview of operation
// - Start rising with data-in high: chip-select mode, output off, convert.
// - Conversion runs to its end whatever data-in does meanwhile.
// - No busy chip-select: data-in falling after conversion drives MSB, then shifts.
// - No busy chip-select: output off after 18th falling edge or release.
// - Output bits change only on falling edges, valid on both edges.
// - Busy chip-select: conversion end drives low busy bit, then MSB.
// - Busy chip-select: output off after 19th falling edge or release.
// - Start rising with data-in low selects daisy-chain mode.
// - Start and data-in both low forces the output driven low.
// - Serial clock level at start rising picks the daisy busy option.
// - Daisy conversion end loads 18-bit register, no busy: MSB at once.
// - Each later falling edge captures data-in and presents next bit.
// - Daisy busy: output driven high at end; one extra edge needed.
// - Upstream busy bit is not passed into the shift stream.
// - After conversion, acquisition phase with circuitry powered down.
// - Result is a two's complement word.
// - Serial clock edges only read data out, during acquisition.
`timescale 1ns/100ps

module adcsr_readout (
  // Clocks and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic sclk_in,
  // Host pins
  input wire logic conversion_start_input_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Converter core
  input wire logic [adcsr_pkg::ADCSR_DATA_W-1:0] sample_in,
  output logic converting_out,
  output logic result_ready_out
);
  import adcsr_pkg::*;

  localparam int CONV_WAIT = ADCSR_CONV_MAX_CYC - 9;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] pins_sync;
  logic conv_s;
  logic sdi_s;
  logic sclk_s;

  adcsr_sync #(
    .WIDTH(3)
  ) adcsr_sync_inst (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .async_in({conversion_start_input_in, sdi_in, sclk_in}),
    .sync_out(pins_sync)
  );

  assign conv_s = pins_sync[2];
  assign sdi_s = pins_sync[1];
  assign sclk_s = pins_sync[0];

  // ********************************************************************
  // Conversion control
  // ********************************************************************
  adcsr_state_e state_reg;
  logic [ADCSR_CNT_W-1:0] cnt_reg;
  logic conv_q_reg;
  logic start_rise;
  logic conv_end;
  logic [ADCSR_DATA_W-1:0] sample_reg;
  logic [ADCSR_DATA_W-1:0] result_reg;
  logic cs_mode_reg;
  logic busy_opt_reg;
  logic busy_reg;
  logic ready_reg;
  logic released_reg;
  logic drive_reg;
  logic force_low_reg;

  assign start_rise = conv_s & ~conv_q_reg;
  assign conv_end = (state_reg == st_convert) && (cnt_reg == ADCSR_CNT_RST);

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_q_reg <= 1'b1;
    end else begin
      conv_q_reg <= conv_s;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= st_acquire;
      cnt_reg <= ADCSR_CNT_RST;
    end else begin
      case (state_reg)
        st_acquire: begin
          if (start_rise) begin
            state_reg <= st_convert;
            cnt_reg <= ADCSR_CONV_LOAD;
          end
        end
        st_convert: begin
          if (cnt_reg == ADCSR_CNT_RST) begin
            state_reg <= st_acquire;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= st_acquire;
        end
      endcase
    end
  end

  // Mode and busy option latched at start
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_mode_reg <= 1'b1;
      busy_opt_reg <= 1'b0;
    end else if (start_rise && state_reg == st_acquire) begin
      cs_mode_reg <= sdi_s;
      busy_opt_reg <= sclk_s;
    end
  end

  // Sample held during conversion, two's complement passed unchanged
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sample_reg <= ADCSR_WORD_RST;
      result_reg <= ADCSR_WORD_RST;
    end else begin
      if (start_rise && state_reg == st_acquire) begin
        sample_reg <= sample_in;
      end
      if (conv_end) begin
        result_reg <= sample_reg;
      end
    end
  end

  // Busy decision at conversion end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_reg <= 1'b0;
    end else if (conv_end) begin
      busy_reg <= cs_mode_reg ? ~sdi_s : busy_opt_reg;
    end
  end

  // Readout window opens at conversion end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_reg <= 1'b0;
    end else if (start_rise && state_reg == st_acquire) begin
      ready_reg <= 1'b0;
    end else if (conv_end) begin
      ready_reg <= 1'b1;
    end
  end

  // Chip-select release ends the read until the next conversion
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      released_reg <= 1'b0;
    end else if (!ready_reg) begin
      released_reg <= 1'b0;
    end else if (cs_mode_reg && sdi_s && drive_reg) begin
      released_reg <= 1'b1;
    end
  end

  // ********************************************************************
  // Output enable
  // ********************************************************************
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drive_reg <= 1'b0;
      force_low_reg <= 1'b0;
    end else if (!sdi_s && !conv_s) begin
      drive_reg <= 1'b1;
      force_low_reg <= 1'b1;
    end else begin
      force_low_reg <= 1'b0;
      if (start_rise || state_reg == st_convert) begin
        drive_reg <= 1'b0;
      end else if (ready_reg && cs_mode_reg) begin
        drive_reg <= ~sdi_s & ~released_reg;
      end else if (ready_reg) begin
        drive_reg <= 1'b1;
      end else begin
        drive_reg <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Serial clock domain
  // ********************************************************************
  logic link_rst_n;
  logic [ADCSR_EDGE_W-1:0] edge_reg;
  logic [ADCSR_DATA_W-1:0] cap_reg;
  logic link_done;
  logic [ADCSR_EDGE_W-1:0] bit_idx;

  // Held in reset outside the readout window
  assign link_rst_n = arst_n_in & ready_reg;

  always_ff @(negedge sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      edge_reg <= ADCSR_EDGE_RST;
    end else if (edge_reg != ADCSR_EDGES_BUSY) begin
      edge_reg <= edge_reg + 5'h01;
    end
  end

  always_ff @(negedge sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cap_reg <= ADCSR_WORD_RST;
    end else if (!(busy_reg && edge_reg == ADCSR_EDGE_RST)) begin
      cap_reg <= {cap_reg[ADCSR_DATA_W-2:0], sdi_in};
    end
  end

  assign link_done = cs_mode_reg &&
    (edge_reg >= (busy_reg ? ADCSR_EDGES_BUSY : ADCSR_EDGES_PLAIN));

  // ********************************************************************
  // Serial output
  // ********************************************************************
  assign bit_idx = busy_reg ? edge_reg - 5'h01 : edge_reg;

  always_comb begin
    if (force_low_reg) begin
      sdo_out = 1'b0;
    end else if (busy_reg && edge_reg == ADCSR_EDGE_RST) begin
      sdo_out = ~cs_mode_reg;
    end else if (bit_idx < ADCSR_EDGES_PLAIN) begin
      sdo_out = result_reg[ADCSR_MSB_POS - bit_idx];
    end else if (cs_mode_reg) begin
      sdo_out = 1'b0;
    end else begin
      sdo_out = cap_reg[ADCSR_DATA_W-1];
    end
  end

  assign sdo_oe_out = drive_reg & (force_low_reg | ~link_done);
  assign converting_out = (state_reg == st_convert);
  assign result_ready_out = ready_reg;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_start_tristate: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (start_rise && state_reg == st_acquire && sdi_s)
      |=> (!drive_reg && cs_mode_reg && state_reg == st_convert))
    else $error("output not released at chip-select start");

  a_mode_select: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (start_rise && state_reg == st_acquire && !sdi_s) |=> !cs_mode_reg)
    else $error("daisy mode not selected");

  a_conv_length: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    $rose(converting_out) |->
      (converting_out [*8] ##1 converting_out [*2])
      ##[1:CONV_WAIT] !converting_out)
    else $error("conversion length out of range");

  a_conv_ignores_cs: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (state_reg == st_convert && cnt_reg != ADCSR_CNT_RST)
      |=> (state_reg == st_convert && cnt_reg == $past(cnt_reg) - 8'h01))
    else $error("conversion disturbed");

  a_both_low: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (!sdi_s && !conv_s) |=> (sdo_oe_out && !sdo_out))
    else $error("output not driven low");

  a_busy_low_bit: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (conv_end && cs_mode_reg && !sdi_s && conv_s)
      ##1 (conv_s && !sdi_s) |=> (sdo_oe_out && !sdo_out))
    else $error("busy bit not low");

  a_daisy_busy_high: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (conv_end && !cs_mode_reg && busy_opt_reg && conv_s)
      ##1 (conv_s && edge_reg == ADCSR_EDGE_RST) |=> (sdo_oe_out && sdo_out))
    else $error("daisy busy bit not high");

  a_daisy_msb: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (conv_end && !cs_mode_reg && !busy_opt_reg && conv_s)
      ##1 (conv_s && edge_reg == ADCSR_EDGE_RST)
      |=> (sdo_oe_out && sdo_out == result_reg[ADCSR_DATA_W-1]))
    else $error("daisy MSB not presented");

  a_power_down: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    conv_end |=> (!converting_out && result_ready_out))
    else $error("no acquisition after conversion");

  a_plain_release: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (cs_mode_reg && !busy_reg && edge_reg == ADCSR_EDGES_PLAIN)
      |-> (!sdo_oe_out || force_low_reg))
    else $error("output on after 18 edges");

  a_busy_release: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (cs_mode_reg && busy_reg && edge_reg == ADCSR_EDGES_BUSY)
      |-> (!sdo_oe_out || force_low_reg))
    else $error("output on after 19 edges");

  a_shift_capture: assert property (
    @(negedge sclk_in) disable iff (!link_rst_n)
    (!busy_reg && !cs_mode_reg) |=> (cap_reg[0] == $past(sdi_in)))
    else $error("data-in not captured");

  a_no_busy_pass: assert property (
    @(negedge sclk_in) disable iff (!link_rst_n)
    (busy_reg && edge_reg == ADCSR_EDGE_RST) |=> (cap_reg == $past(cap_reg)))
    else $error("upstream busy bit passed on");

  c_cs_plain: cover property (
    @(posedge clock_in) disable iff (!arst_n_in)
    cs_mode_reg && !busy_reg && edge_reg == ADCSR_EDGES_PLAIN);

  c_cs_busy: cover property (
    @(posedge clock_in) disable iff (!arst_n_in)
    cs_mode_reg && busy_reg && edge_reg == ADCSR_EDGES_BUSY);

  c_daisy_plain: cover property (
    @(negedge sclk_in) disable iff (!link_rst_n)
    !cs_mode_reg && !busy_reg && edge_reg == ADCSR_EDGES_BUSY);

  c_daisy_busy: cover property (
    @(negedge sclk_in) disable iff (!link_rst_n)
    !cs_mode_reg && busy_reg && edge_reg == ADCSR_EDGES_BUSY);

endmodule

// [core/adcsr_sync.sv]
/*
  Two-stage level synchroniser for pins entering the system clock domain.
  Assumes each bit is a slow level; no bus coherency is promised.
*/
`timescale 1ns/100ps

module adcsr_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ********************************************************************
  // Two flip-flops per bit
  // ********************************************************************
  logic [WIDTH-1:0] meta_reg;

  // Reset high to match idle pins, so no false edge or both-low
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [verification/adc_serial_readout_modes_bench.sv]
/*
  Self-checking bench for the serial readout block in its chip-select
  and daisy-chain modes, with and without the busy bit.
  Assumes the host model in adcsr_host and a 20 MHz system clock.
*/
`timescale 1ns/100ps

`define ADCSR_CHK(name, exp, got) \
  begin \
    checks_done++; \
    if ((exp) !== (got)) begin \
      err_total++; \
      $display("MISMATCH %s expected %h seen %h", name, exp, got); \
    end \
  end

module adc_serial_readout_modes_bench;
  import adcsr_pkg::*;

  logic clock;
  logic arst_n;
  logic start;
  logic sdi;
  logic sclk;
  logic sdo;
  logic sdo_oe;
  logic [ADCSR_DATA_W-1:0] sample;
  logic converting;
  logic result_ready;
  int err_total = 0;
  int checks_done = 0;
  int cycle_count = 0;

  adcsr_readout adcsr_readout_inst (
    .clock_in(clock),
    .arst_n_in(arst_n),
    .sclk_in(sclk),
    .conversion_start_input_in(start),
    .sdi_in(sdi),
    .sdo_out(sdo),
    .sdo_oe_out(sdo_oe),
    .sample_in(sample),
    .converting_out(converting),
    .result_ready_out(result_ready)
  );

  adcsr_host adcsr_host_inst (
    .clock_in(clock),
    .sdo_in(sdo),
    .sdo_oe_in(sdo_oe),
    .start_out(start),
    .sdi_out(sdi),
    .sclk_out(sclk)
  );

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      err_total++;
      finish_test();
    end
  end

  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp_bits(input int n, input logic [0:63] exp);
    for (int i = 0; i < n; i++) begin
      logic lo;
      logic hi;
      lo = adcsr_host_inst.rx_lo[i];
      hi = adcsr_host_inst.rx_hi[i];
      `ADCSR_CHK("serial bit", exp[i], lo)
      `ADCSR_CHK("bit on both edges", lo, hi)
    end
  endtask

  // Counts conversion cycles; optionally moves data-in meanwhile
  task automatic wait_conv(input logic drive, input logic mid,
                           input logic fin);
    int len;
    int guard;
    len = 0;
    guard = 0;
    while (converting !== 1'b1 && guard < 20) begin
      @(negedge clock);
      guard++;
    end
    while (converting === 1'b1 && len < 100) begin
      @(negedge clock);
      len++;
      if (drive && len == 2) adcsr_host_inst.sdi_out = mid;
      if (len == 4) `ADCSR_CHK("drive in conversion", 1'b0, sdo_oe)
      if (len == 3) adcsr_host_inst.sclk_out = 1'b0;
      if (drive && len == 6) adcsr_host_inst.sdi_out = fin;
    end
    `ADCSR_CHK("conversion cycles", ADCSR_CONV_CYC, len)
    `ADCSR_CHK("result ready", 1'b1, result_ready)
    repeat (4) @(negedge clock);
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_reset();
    repeat (3) @(negedge clock);
    `ADCSR_CHK("idle drive", 1'b0, sdo_oe)
    `ADCSR_CHK("idle converting", 1'b0, converting)
    `ADCSR_CHK("idle ready", 1'b0, result_ready)
  endtask

  task automatic t_cs(input logic busy);
    logic [0:63] exp;
    exp = '0;
    sample = busy ? 18'h2_0001 : 18'h1_fffe;
    adcsr_host_inst.prepare(1'b1, 1'b0);
    adcsr_host_inst.raise_start();
    wait_conv(1'b1, 1'b0, ~busy);
    if (busy) begin
      `ADCSR_CHK("busy drive", 1'b1, sdo_oe)
      `ADCSR_CHK("busy level", 1'b0, sdo)
      exp[0:18] = {1'b0, sample};
    end else begin
      `ADCSR_CHK("no busy drive", 1'b0, sdo_oe)
      adcsr_host_inst.set_sdi(1'b0);
      repeat (4) @(negedge clock);
      `ADCSR_CHK("select drive", 1'b1, sdo_oe)
      `ADCSR_CHK("msb on select", sample[17], sdo)
      exp[0:17] = sample;
    end
    adcsr_host_inst.xfer(busy ? 19 : 18, '0);
    cmp_bits(busy ? 19 : 18, exp);
    `ADCSR_CHK("off after count", 1'b0, sdo_oe)
    `ADCSR_CHK("line free", 1'b1, adcsr_host_inst.line_level)
    adcsr_host_inst.set_sdi(1'b1);
  endtask

  task automatic t_cs_release();
    logic [0:63] exp;
    exp = '0;
    sample = 18'h2_a5c3;
    exp[0:17] = sample;
    adcsr_host_inst.prepare(1'b1, 1'b0);
    adcsr_host_inst.raise_start();
    wait_conv(1'b1, 1'b0, 1'b1);
    adcsr_host_inst.set_sdi(1'b0);
    repeat (4) @(negedge clock);
    adcsr_host_inst.xfer(5, '0);
    cmp_bits(5, exp);
    `ADCSR_CHK("held mid word", 1'b1, sdo_oe)
    adcsr_host_inst.set_sdi(1'b1);
    repeat (4) @(negedge clock);
    `ADCSR_CHK("off on release", 1'b0, sdo_oe)
  endtask

  task automatic t_daisy(input logic busy);
    logic [0:63] exp;
    logic [0:63] stream;
    logic [ADCSR_DATA_W-1:0] up;
    exp = '0;
    stream = '0;
    up = 18'h0_f1c3;
    sample = busy ? 18'h1_5a3c : 18'h0_8421;
    adcsr_host_inst.prepare(1'b0, busy);
    `ADCSR_CHK("both low drive", 1'b1, sdo_oe)
    `ADCSR_CHK("both low level", 1'b0, sdo)
    adcsr_host_inst.raise_start();
    wait_conv(1'b0, 1'b0, 1'b0);
    `ADCSR_CHK("chain drive", 1'b1, sdo_oe)
    `ADCSR_CHK("chain first", busy ? 1'b1 : sample[17], sdo)
    if (busy) begin
      stream[0:18] = {1'b1, up};
      exp[0:36] = {1'b1, sample, up};
    end else begin
      stream[0:17] = up;
      exp[0:35] = {sample, up};
    end
    adcsr_host_inst.xfer(busy ? 37 : 36, stream);
    cmp_bits(busy ? 37 : 36, exp);
  endtask

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    sample = '0;
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    t_reset();
    t_cs(1'b0);
    t_cs(1'b1);
    t_cs_release();
    t_daisy(1'b0);
    t_daisy(1'b1);
    finish_test();
  end
endmodule

// [verification/adcsr_host.sv]
/*
  Host model for the serial readout block: drives start, data-in and the
  serial clock, and captures the serial output line.
  Assumes a pull-up on the output line and a 80 ns serial clock period.
*/
`timescale 1ns/100ps

module adcsr_host (
  // Timing reference
  input wire logic clock_in,
  // Device pins
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic start_out,
  output logic sdi_out,
  output logic sclk_out
);
  logic line_level;
  logic [0:63] rx_lo;
  logic [0:63] rx_hi;

  // Pull-up holds the line high when released
  assign line_level = sdo_oe_in ? sdo_in : 1'b1;

  initial begin
    start_out = 1'b0;
    sdi_out = 1'b1;
    sclk_out = 1'b0;
    rx_lo = '0;
    rx_hi = '0;
  end

  // ********************************************************************
  // Host actions
  // ********************************************************************
  task automatic set_sdi(input logic level);
    @(negedge clock_in);
    sdi_out = level;
  endtask

  // Mode levels first, then start low for a few cycles
  task automatic prepare(input logic cs_mode, input logic busy_sel);
    @(negedge clock_in);
    sdi_out = cs_mode;
    sclk_out = busy_sel;
    repeat (2) @(negedge clock_in);
    start_out = 1'b0;
    repeat (4) @(negedge clock_in);
  endtask

  // Start stays high until readout is over
  task automatic raise_start();
    @(negedge clock_in);
    start_out = 1'b1;
  endtask

  // Serial clock runs only inside a frame; data-in moves after falls
  task automatic xfer(input int n, input logic [0:63] stream);
    for (int i = 0; i < n; i++) begin
      #10 sdi_out = stream[i];
      #10 rx_lo[i] = line_level;
      #20 sclk_out = 1'b1;
      #20 rx_hi[i] = line_level;
      #20 sclk_out = 1'b0;
    end
    #40;
  endtask
endmodule
